// ===== common/xor_decode_regs.svh
// Constants for the exclusive-OR and extended set decoder.
`ifndef XOR_DECODE_REGS_SVH
`define XOR_DECODE_REGS_SVH
`define OPC_XOR_FILE     6'h06
`define OPC_EXT_HI       4'hE
`define EXT_ADD_PTR      4'h8
`define EXT_SUB_PTR      4'h9
`define EXT_PUSH_LIT     4'hA
`define EXT_MOVE_IDX     4'hB
`define OPC_EXT_SECOND   4'hF
`define CALL_W_WORD      16'h0014
`define IDX_LIMIT        8'h5F
`define BIT_DEST         9
`define BIT_BANK         8
`define RST_ACC          8'h00
`define RST_PTR          12'h000
`define POINTER_TWO      2'h3
`endif

// ===== common/xor_decode_pkg.sv
// Types shared by the exclusive-OR and extended set decoder.
package xor_decode_pkg;
	// Class of the instruction being executed.
	typedef enum logic [2:0] {
		CLS_NONE,
		CLS_XOR,
		CLS_PTR,
		CLS_PTR_RET,
		CLS_EXT_OTHER
	} instr_class_t;
endpackage

// ===== core/xor_file_and_extended_set_decode.sv
// Decoder and executer for xor with file plus the extended set.
// Summary of operation
// - Result is accumulator xor addressed file register.
// - Destination bit zero picks accumulator, one file.
// - Bank bit zero access bank, one bank select.
// - Indexed mode: bank zero, extended on, f<=95.
// - Extended features off after reset until enabled.
// - Standard set always; eight extras when enabled.
// - Extended add/subtract instructions are literal pointer operations.
// - Pointer-two add/subtract variants then return.
`timescale 1ns/10ps
`default_nettype none
`include "xor_decode_regs.svh"
module xor_file_and_extended_set_decode
	import xor_decode_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst,
	// Instruction stream.
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	// Extended set enable configuration bit, from a pin.
	input  wire logic        extended_set_enable_config,
	// Bank select register value from the core.
	input  wire logic [3:0]  bank_select_register,
	// File data read back for the addressed register.
	input  wire logic [7:0]  file_rdata,
	// File write port.
	output logic             file_we,
	output logic [11:0]      file_addr,
	output logic [7:0]       file_wdata,
	// Read address (combinational) for the current instruction.
	output logic [11:0]      file_raddr,
	// Core state views.
	output logic [7:0]       acc_out,
	output logic             zero_flag,
	output logic             negative_flag,
	output logic             indexed_mode,
	output logic             ext_active,
	output logic             return_req,
	output logic             ext_decoded,
	output logic [11:0]      pointer0,
	output logic [11:0]      pointer1,
	output logic [11:0]      pointer_two
);
	// Three-stage synchroniser for the configuration pin.
	logic       cfg_s1_ff, cfg_s2_ff, cfg_s3_ff;
	logic       nxt_cfg_s1, nxt_cfg_s2, nxt_cfg_s3;
	// Filtered enable, cleared by reset.
	logic       ext_en_ff, nxt_ext_en;
	// Architectural state.
	logic [7:0] acc_ff, nxt_acc;
	logic       zero_ff, nxt_zero, neg_ff, nxt_neg;
	logic [11:0] ptr_ff [0:2];
	logic [11:0] nxt_ptr [0:2];
	// Registered outputs.
	logic       we_ff, nxt_we, idx_ff, nxt_idx, ret_ff, nxt_ret;
	logic       extd_ff, nxt_extd;
	logic [11:0] waddr_ff, nxt_waddr;
	logic [7:0] wdata_ff, nxt_wdata;
	// Decode products.
	instr_class_t cls;
	logic [7:0]   xor_res;
	logic [1:0]   psel;

	// Pointer plus or minus a six-bit literal.
	function automatic logic [11:0] ptr_adj(input logic [11:0] p,
		input logic [5:0] k, input logic sub);
		if (sub) begin
			ptr_adj = p - {6'h00, k};
		end else begin
			ptr_adj = p + {6'h00, k};
		end
	endfunction

	// Classify the word; extended opcodes count only when enabled.
	always_comb begin
		cls = CLS_NONE;
		if (instr_word[15:10] == `OPC_XOR_FILE) begin
			cls = CLS_XOR;
		end else if (ext_en_ff && instr_word[15:12] == `OPC_EXT_HI) begin
			if (instr_word[11:8] == `EXT_ADD_PTR ||
			    instr_word[11:8] == `EXT_SUB_PTR) begin
				// Literal operation on a pointer.
				if (instr_word[7:6] == `POINTER_TWO) begin
					cls = CLS_PTR_RET;
				end else begin
					cls = CLS_PTR;
				end
			end else if (instr_word[11:8] == `EXT_PUSH_LIT ||
			             instr_word[11:8] == `EXT_MOVE_IDX) begin
				cls = CLS_EXT_OTHER;
			end
		end else if (ext_en_ff && (instr_word == `CALL_W_WORD ||
		             instr_word[15:12] == `OPC_EXT_SECOND)) begin
			cls = CLS_EXT_OTHER;
		end
	end

	// Addressing for the xor: indexed, access bank or banked.
	always_comb begin
		nxt_idx = 1'b0;
		psel = instr_word[7:6];
		if (!instr_word[`BIT_BANK] && ext_en_ff &&
		    instr_word[7:0] <= `IDX_LIMIT) begin
			// Only an executed xor may report the indexed mode.
			nxt_idx = instr_valid && (cls == CLS_XOR);
			file_raddr = ptr_ff[2] + {4'h0, instr_word[7:0]};
		end else if (!instr_word[`BIT_BANK]) begin
			// Access bank: low half low page, high half top page.
			file_raddr = {{4{instr_word[7]}}, instr_word[7:0]};
		end else begin
			file_raddr = {bank_select_register, instr_word[7:0]};
		end
		xor_res = acc_ff ^ file_rdata;
	end

	// Next state for every register.
	always_comb begin
		nxt_cfg_s1 = extended_set_enable_config;
		nxt_cfg_s2 = cfg_s1_ff;
		nxt_cfg_s3 = cfg_s2_ff;
		nxt_ext_en = ext_en_ff;
		if (cfg_s2_ff == cfg_s3_ff) begin
			nxt_ext_en = cfg_s3_ff;
		end
		nxt_acc = acc_ff;
		nxt_zero = zero_ff;
		nxt_neg = neg_ff;
		nxt_we = 1'b0;
		nxt_waddr = waddr_ff;
		nxt_wdata = wdata_ff;
		nxt_ret = 1'b0;
		nxt_extd = 1'b0;
		for (int i = 0; i < 3; i++) begin
			nxt_ptr[i] = ptr_ff[i];
		end
		if (instr_valid) begin
			unique case (cls)
				CLS_XOR: begin
					if (instr_word[`BIT_DEST]) begin
						nxt_we = 1'b1;
						nxt_waddr = file_raddr;
						nxt_wdata = xor_res;
					end else begin
						nxt_acc = xor_res;
					end
					nxt_zero = (xor_res == 8'h00);
					nxt_neg = xor_res[7];
				end
				CLS_PTR, CLS_PTR_RET: begin
					nxt_extd = 1'b1;
					if (psel != `POINTER_TWO) begin
						nxt_ptr[psel] = ptr_adj(ptr_ff[psel],
							instr_word[5:0], instr_word[8]);
					end else begin
						nxt_ptr[2] = ptr_adj(ptr_ff[2], instr_word[5:0],
							instr_word[8]);
						nxt_ret = 1'b1;
					end
				end
				CLS_EXT_OTHER: begin
					nxt_extd = 1'b1;
				end
				CLS_NONE: begin
				end
			endcase
		end
	end

	// Register stage; reset leaves extended features disabled.
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_s1_ff <= 1'b0;
			cfg_s2_ff <= 1'b0;
			cfg_s3_ff <= 1'b0;
			ext_en_ff <= 1'b0;
			acc_ff <= `RST_ACC;
			zero_ff <= 1'b0;
			neg_ff <= 1'b0;
			we_ff <= 1'b0;
			idx_ff <= 1'b0;
			ret_ff <= 1'b0;
			extd_ff <= 1'b0;
			waddr_ff <= `RST_PTR;
			wdata_ff <= `RST_ACC;
			for (int i = 0; i < 3; i++) begin
				ptr_ff[i] <= `RST_PTR;
			end
		end else begin
			cfg_s1_ff <= nxt_cfg_s1;
			cfg_s2_ff <= nxt_cfg_s2;
			cfg_s3_ff <= nxt_cfg_s3;
			ext_en_ff <= nxt_ext_en;
			acc_ff <= nxt_acc;
			zero_ff <= nxt_zero;
			neg_ff <= nxt_neg;
			we_ff <= nxt_we;
			idx_ff <= nxt_idx;
			ret_ff <= nxt_ret;
			extd_ff <= nxt_extd;
			waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;
			for (int i = 0; i < 3; i++) begin
				ptr_ff[i] <= nxt_ptr[i];
			end
		end
	end

	// Output drive.
	assign file_we = we_ff;
	assign file_addr = waddr_ff;
	assign file_wdata = wdata_ff;
	assign acc_out = acc_ff;
	assign zero_flag = zero_ff;
	assign negative_flag = neg_ff;
	assign indexed_mode = idx_ff;
	assign ext_active = ext_en_ff;
	assign return_req = ret_ff;
	assign ext_decoded = extd_ff;
	assign pointer0 = ptr_ff[0];
	assign pointer1 = ptr_ff[1];
	assign pointer_two = ptr_ff[2];

	// Xor to file writes the xor of accumulator and file data.
	AST_XOR_TO_FILE: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && cls == CLS_XOR && instr_word[`BIT_DEST]
		|=> file_we && file_addr == $past(file_raddr)
		&& file_wdata == ($past(acc_ff) ^ $past(file_rdata)))
		else $error("xor result to file wrong");
	// Destination zero loads accumulator, no file write.
	AST_XOR_TO_ACC: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && cls == CLS_XOR && !instr_word[`BIT_DEST]
		|=> !file_we && acc_ff == ($past(acc_ff) ^ $past(file_rdata)))
		else $error("xor result to accumulator wrong");
	// Banked address uses bank select register.
	AST_BANKED: assert property (
		@(posedge mclk) disable iff (rst)
		instr_word[`BIT_BANK]
		|-> file_raddr == {bank_select_register, instr_word[7:0]})
		else $error("banked address wrong");
	// Access bank outside the indexed window: low or top page.
	AST_ACCESS_BANK: assert property (
		@(posedge mclk) disable iff (rst)
		!instr_word[`BIT_BANK]
		&& !(ext_en_ff && instr_word[7:0] <= `IDX_LIMIT)
		|-> file_raddr == {{4{instr_word[7]}}, instr_word[7:0]})
		else $error("access bank address wrong");
	// Indexed mode only with all three conditions.
	AST_INDEXED: assert property (
		@(posedge mclk) disable iff (rst)
		indexed_mode |-> $past(ext_en_ff) && !$past(instr_word[8])
		&& $past(instr_word[7:0]) <= `IDX_LIMIT)
		else $error("indexed mode without its conditions");
	// Indexed reads offset the pointer-two base by the operand.
	AST_INDEXED_ADDR: assert property (
		@(posedge mclk) disable iff (rst)
		!instr_word[`BIT_BANK] && ext_en_ff
		&& instr_word[7:0] <= `IDX_LIMIT
		|-> file_raddr == pointer_two + {4'h0, instr_word[7:0]})
		else $error("indexed address wrong");
	// An xor that meets all three conditions reports indexed mode.
	AST_INDEXED_SET: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && cls == CLS_XOR && !instr_word[`BIT_BANK]
		&& ext_en_ff && instr_word[7:0] <= `IDX_LIMIT
		|=> indexed_mode)
		else $error("indexed mode missing");
	// Extended set stays off for three cycles after reset.
	AST_EXT_OFF: assert property (
		@(posedge mclk)
		$fell(rst) |-> !ext_active [*3])
		else $error("extended set active right after reset");
	// Nothing extended shows while the enable was low.
	AST_EXT_QUIET: assert property (
		@(posedge mclk) disable iff (rst)
		!$past(ext_active) |-> !indexed_mode && !ext_decoded
		&& !return_req)
		else $error("extended effect while disabled");
	// Extended opcodes ignored while disabled.
	AST_EXT_GATED: assert property (
		@(posedge mclk) disable iff (rst)
		ext_decoded |-> $past(ext_en_ff))
		else $error("extended decoded while disabled");
	// Enabled extended first words with codes 8 to B are all decoded.
	AST_EXT_SEEN: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && ext_en_ff && instr_word[15:12] == `OPC_EXT_HI
		&& instr_word[11:10] == 2'h2
		|=> ext_decoded)
		else $error("extended word not decoded");
	// Pointer zero add updates by the literal.
	AST_PTR_ADD: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && cls == CLS_PTR && instr_word[11:6] == 6'h20
		|=> pointer0 == $past(pointer0) + {6'h00, $past(instr_word[5:0])})
		else $error("pointer add wrong");
	// Non-xor words leave accumulator and file memory alone.
	AST_EXT_LITERAL: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && cls != CLS_XOR
		|=> !file_we && acc_out == $past(acc_out))
		else $error("extended word touched data");
	// Pointer-two variant requests a return.
	AST_RETURN: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && cls == CLS_PTR_RET |=> return_req)
		else $error("return not requested");
	// A return request only follows a pointer-two variant.
	AST_RETURN_ONLY: assert property (
		@(posedge mclk) disable iff (rst)
		return_req |-> $past(instr_valid) && $past(cls == CLS_PTR_RET))
		else $error("return requested without cause");
	// Flags follow the xor result.
	AST_FLAGS: assert property (
		@(posedge mclk) disable iff (rst)
		instr_valid && cls == CLS_XOR |=> zero_flag ==
		(($past(acc_ff) ^ $past(file_rdata)) == 8'h00)
		&& negative_flag == $past(acc_ff[7] ^ file_rdata[7]))
		else $error("flags wrong");
endmodule
`default_nettype wire

// ===== tb/test_xor_file_and_extended_set_decode.sv
// Self-checking bench for the xor and extended set decoder.
`timescale 1ns/10ps
`default_nettype none
`include "xor_decode_regs.svh"
module test_xor_file_and_extended_set_decode;
	import xor_decode_pkg::*;
	// Stimulus driven into the decoder.
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic        extended_set_enable_config = 1'b0;
	logic [3:0]  bank_select_register = 4'h3;
	logic [7:0]  file_rdata = 8'h00;
	// Outputs observed from the decoder.
	logic        file_we, zero_flag, negative_flag, indexed_mode;
	logic        ext_active, return_req, ext_decoded;
	logic [11:0] file_addr, file_raddr, pointer0, pointer1, pointer_two;
	logic [7:0]  file_wdata, acc_out;
	logic [11:0] raddr_seen; // Read address seen while the word was held.
	int          failures = 0;
	int          checked = 0;
	int          cycles = 0;

	xor_file_and_extended_set_decode u_xor_file_and_extended_set_decode (
		.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
		.instr_word(instr_word),
		.extended_set_enable_config(extended_set_enable_config),
		.bank_select_register(bank_select_register),
		.file_rdata(file_rdata), .file_we(file_we), .file_addr(file_addr),
		.file_wdata(file_wdata), .file_raddr(file_raddr),
		.acc_out(acc_out), .zero_flag(zero_flag),
		.negative_flag(negative_flag), .indexed_mode(indexed_mode),
		.ext_active(ext_active), .return_req(return_req),
		.ext_decoded(ext_decoded), .pointer0(pointer0),
		.pointer1(pointer1), .pointer_two(pointer_two));

	// A 40 ns clock.
	always #20 mclk = ~mclk;

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// A hang is cut short well after the sequence should be over.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			conclude();
		end
	end

	// Compares one observed value with its expectation.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
	                   input string what);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time,
			         what, got, exp);
		end
	endtask

	// Builds an xor-with-file word from its fields.
	function automatic logic [15:0] xw(input logic d, input logic a,
	                                   input logic [7:0] f);
		return {`OPC_XOR_FILE, d, a, f};
	endfunction

	// Presents one word for one cycle; results are read one cycle later.
	task automatic issue(input logic [15:0] w, input logic [7:0] rd);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word  <= w;
		file_rdata  <= rd;
		#1 raddr_seen = file_raddr;
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
	endtask

	// Main sequence: standard xor first, then extended set off and on.
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		#1 chk(ext_active, 1'b0, "ext after reset");
		chk(acc_out, 8'h00, "acc after reset");
		issue(xw(1'b0, 1'b1, 8'h05), 8'hB5);
		chk(raddr_seen, 12'h305, "bank addr");
		chk(acc_out, 8'hB5, "acc d0");
		chk(file_we, 1'b0, "no write d0");
		chk({zero_flag, negative_flag}, 2'b01, "flags B5");
		issue(xw(1'b1, 1'b1, 8'h10), 8'hAF);
		chk(file_we, 1'b1, "write d1");
		chk(file_wdata, 8'h1A, "wdata");
		chk(file_addr, 12'h310, "waddr");
		chk(acc_out, 8'hB5, "acc kept d1");
		issue(xw(1'b0, 1'b0, 8'h20), 8'hB5);
		chk(raddr_seen, 12'h020, "access addr");
		chk(indexed_mode, 1'b0, "indexed off");
		chk({zero_flag, negative_flag}, 2'b10, "flags zero");
		issue(xw(1'b1, 1'b0, 8'h85), 8'h3C);
		chk(raddr_seen, 12'hF85, "access top addr");
		chk(file_addr, 12'hF85, "access top waddr");
		chk(file_wdata, 8'h3C, "wdata top");
		issue(16'hE8C5, 8'h00);
		chk(ext_decoded, 1'b0, "ext refused");
		chk(pointer_two, 12'h000, "ptr2 kept");
		issue(16'hF123, 8'h00);
		chk(ext_decoded, 1'b0, "second refused");
		// Enable at a clock edge and wait out the synchroniser.
		@(posedge mclk);
		extended_set_enable_config <= 1'b1;
		repeat (5) @(posedge mclk);
		#1 chk(ext_active, 1'b1, "ext on");
		issue(16'hE8C5, 8'h00);
		chk(pointer_two, 12'h005, "ptr2 add");
		chk({return_req, ext_decoded}, 2'b11, "add ret");
		issue(16'hE9C2, 8'h00);
		chk(pointer_two, 12'h003, "ptr2 sub");
		chk(return_req, 1'b1, "sub ret");
		issue(16'hE843, 8'h00);
		chk(pointer1, 12'h003, "ptr1 add");
		chk({return_req, ext_decoded}, 2'b01, "no ret");
		issue(16'hE807, 8'h00);
		chk(pointer0, 12'h007, "ptr0 add");
		issue(16'hE902, 8'h00);
		chk(pointer0, 12'h005, "ptr0 sub");
		chk({return_req, ext_decoded}, 2'b01, "ptr0 no ret");
		issue(xw(1'b0, 1'b0, 8'h5F), 8'h11);
		chk(raddr_seen, 12'h062, "indexed addr");
		chk(indexed_mode, 1'b1, "indexed 5F");
		chk(acc_out, 8'h11, "acc indexed");
		issue(xw(1'b0, 1'b0, 8'h60), 8'h11);
		chk(raddr_seen, 12'h060, "limit addr");
		chk(indexed_mode, 1'b0, "indexed 60");
		issue(xw(1'b0, 1'b1, 8'h05), 8'h00);
		chk(indexed_mode, 1'b0, "indexed a1");
		issue(16'hE881, 8'h00);
		chk(pointer_two, 12'h004, "ptr2 plain add");
		chk({return_req, ext_decoded}, 2'b01, "ptr2 no ret");
		issue(xw(1'b1, 1'b0, 8'h10), 8'h22);
		chk(file_addr, 12'h014, "indexed waddr");
		chk({file_we, indexed_mode}, 2'b11, "indexed write");
		chk(file_wdata, 8'h22, "indexed wdata");
		issue(16'hEA12, 8'h00);
		chk(ext_decoded, 1'b1, "push lit");
		issue(16'hEB05, 8'h00);
		chk(ext_decoded, 1'b1, "move idx");
		issue(16'h0014, 8'h00);
		chk(ext_decoded, 1'b1, "call w");
		issue(16'hF123, 8'h00);
		chk(ext_decoded, 1'b1, "second word");
		conclude();
	end
endmodule
`default_nettype wire
